/* File: design/asr_pkg.sv */
`default_nettype none
package asr_pkg;

  // Geometry of the memory port
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // System clock period in picoseconds
  localparam int CLK_PS = 5000;

  // Worst-grade timing figures in ns
  localparam int T_CYCLE_NS      = 15;  // Read and write cycle minimum
  localparam int T_WP_NS         = 10;  // Strobe low width, gate high
  localparam int T_STROBE_HZ_NS  = 7;   // Strobe fall to outputs released
  localparam int T_DATA_SETUP_NS = 7;   // Data valid before end of write
  localparam int T_ADDR_SETUP_NS = 10;  // Address valid before end of write
  localparam int T_CS_WRITE_NS   = 10;  // Select low before end of write
  localparam int T_ACCESS_NS     = 15;  // Address or select access
  localparam int T_GATE_ACC_NS   = 7;   // Output gate to valid data
  localparam int T_GATE_HZ_NS    = 7;   // Gate or select high to outputs float
  localparam int T_WRITE_OUT_NS  = 3;   // End of write to device drive again

  // Least times rounded up to whole cycles
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Write strobe low width with gate low: float time plus data setup
  localparam int WP_CYC    = cyc_up(T_STROBE_HZ_NS + T_DATA_SETUP_NS);
  // Read sample point: later of select access and gate access
  localparam int RD_CYC    = cyc_up(T_ACCESS_NS);
  // Bus turnaround after a read or a write
  localparam int TURN_CYC  = cyc_up(T_GATE_HZ_NS);
  localparam int CNT_W     = 4;

  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_READ,
    ASR_WRITE,
    ASR_TURN
  } asr_state_e;

endpackage
`default_nettype wire

/* File: design/asr_hold_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module asr_hold_reg #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         rst,      // Sync reset, active high
  input  wire logic         load,     // Capture strobe
  input  wire logic [W-1:0] din,      // Data to capture
  output logic      [W-1:0] dout      // Registered data
);

  // Holding register for captured words
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dout <= '0;
    else if (load)
      dout <= din;
  end

endmodule
`default_nettype wire

/* File: design/asr_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module asr_ctrl (
  input  wire logic                       clk_sys,    // System clock
  input  wire logic                       rst,        // Sync reset, active high
  input  wire logic                       req_valid,  // Access request
  output logic                            req_ready,  // Request accepted
  input  wire logic                       req_write,  // 1 write, 0 read
  input  wire logic [asr_pkg::ADDR_W-1:0] req_addr,   // Byte address
  input  wire logic [asr_pkg::DATA_W-1:0] req_wdata,  // Write byte
  output logic                            rsp_valid,  // Read data pulse
  output logic      [asr_pkg::DATA_W-1:0] rsp_rdata,  // Read byte
  output logic      [asr_pkg::ADDR_W-1:0] addr_lines, // Memory address pins
  output logic                            cs_n,       // Chip select, low
  output logic                            we_n,       // Write strobe, low
  output logic                            oe_n,       // Output gate, low
  input  wire logic [asr_pkg::DATA_W-1:0] data_in,    // Data lines in
  output logic      [asr_pkg::DATA_W-1:0] data_out,   // Data lines out
  output logic                            data_oe     // Data drive enable
);

  asr_pkg::asr_state_e          state;
  logic [asr_pkg::CNT_W-1:0]    cnt;
  logic                         rd_take;
  logic                         accept;

  localparam logic [asr_pkg::CNT_W-1:0] WP_N   = asr_pkg::CNT_W'(asr_pkg::WP_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] RD_N   = asr_pkg::CNT_W'(asr_pkg::RD_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] TURN_N = asr_pkg::CNT_W'(asr_pkg::TURN_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // Handshake
  assign req_ready = (state == asr_pkg::ASR_IDLE);
  assign accept    = req_valid && req_ready;
  assign rd_take   = (state == asr_pkg::ASR_READ) && (cnt == RD_N - 1'b1);

  // Sequencer state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state <= asr_pkg::ASR_IDLE;
    else
    begin
      unique case (state)
        asr_pkg::ASR_IDLE:
          if (accept)
            state <= req_write ? asr_pkg::ASR_WRITE : asr_pkg::ASR_READ;
        asr_pkg::ASR_READ:
          if (rd_take)
            state <= asr_pkg::ASR_TURN;
        asr_pkg::ASR_WRITE:
          if (cnt == WP_N - 1'b1)
            state <= asr_pkg::ASR_TURN;
        asr_pkg::ASR_TURN:
          if (cnt == TURN_N - 1'b1)
            state <= asr_pkg::ASR_IDLE;
        default:
          state <= asr_pkg::ASR_IDLE;
      endcase
    end
  end

  // Phase counter, cleared on entering read, write or turnaround
  always_ff @(posedge clk_sys)
  begin
    if (rst || accept || rd_take)
      cnt <= '0;
    else if (state == asr_pkg::ASR_WRITE && cnt == WP_N - 1'b1)
      cnt <= '0;
    else if (state != asr_pkg::ASR_IDLE)
      cnt <= cnt + 1'b1;
  end

  // Address held through the whole cycle and the turnaround
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      addr_lines <= '0;
    else if (accept)
      addr_lines <= req_addr;
  end

  // Select and one strobe, write strobe or output gate, asserted together with the address
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cs_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end
    else if (accept)
    begin
      cs_n <= 1'b0;
      we_n <= !req_write;
      oe_n <= req_write;
    end
    else if (rd_take || (state == asr_pkg::ASR_WRITE && cnt == WP_N - 1'b1))
    begin
      cs_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end
  end

  // Write data lane; held one cycle past the strobe rise
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end
    else if (accept && req_write)
    begin
      data_out <= req_wdata;
      data_oe  <= 1'b1;
    end
    else if (state == asr_pkg::ASR_TURN)
      data_oe  <= 1'b0;
  end

  // Read capture register
  asr_hold_reg #(.W(asr_pkg::DATA_W)) u_rd (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (rd_take),
    .din     (data_in),
    .dout    (rsp_rdata)
  );

  // Read completion pulse
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= rd_take;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence wr_start_s;
    accept && req_write;
  endsequence

  sequence rd_start_s;
    accept && !req_write;
  endsequence

  // Strobe low for the counted width, then released
  sequence wr_pulse_s;
    (!we_n)[*3] ##1 we_n;
  endsequence

  joint_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    !we_n |-> !cs_n)
    else $error("strobe low without select");

  strobe_width_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_start_s |=> wr_pulse_s)
    else $error("write strobe too short");

  cs_width_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_start_s |=> (!cs_n)[*3] ##1 cs_n)
    else $error("select short in write");

  addr_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cs_n && !$rose(!cs_n)) |-> $stable(addr_lines))
    else $error("address moved in cycle");

  data_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(we_n) && $past(!cs_n) |-> data_oe)
    else $error("write data dropped early");

  no_contention_a: assert property (@(posedge clk_sys) disable iff (rst)
    data_oe |-> oe_n)
    else $error("drive with gate low");

  read_strobe_a: assert property (@(posedge clk_sys) disable iff (rst)
    rd_start_s |=> (we_n && !cs_n)[*3] ##0 we_n)
    else $error("strobe low in read");

  read_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
    rd_start_s |-> ##3 rd_take ##1 rsp_valid)
    else $error("read sampled at wrong time");

  wr_data_lead_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_start_s |=> (data_oe && !we_n)[*3] ##1 (data_oe && we_n))
    else $error("write data not around strobe");

  rd_turnaround_a: assert property (@(posedge clk_sys) disable iff (rst)
    rd_start_s |=> (!cs_n)[*3] ##1 (cs_n && !data_oe)[*3])
    else $error("drive too soon after read");

  addr_at_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(addr_lines) |-> $fell(cs_n))
    else $error("address moved off select fall");

endmodule
`default_nettype wire

/* File: test/asr_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model (
  input  wire logic                       clk_sys,    // Clock for float pattern
  input  wire logic                       slow,       // Slow access when high
  input  wire logic [asr_pkg::ADDR_W-1:0] addr_lines, // Address pins
  input  wire logic                       cs_n,       // Chip select, low
  input  wire logic                       we_n,       // Write strobe, low
  input  wire logic                       oe_n,       // Output gate, low
  input  wire logic [asr_pkg::DATA_W-1:0] data_out,   // Controller drive value
  input  wire logic                       data_oe,    // Controller drives
  output logic      [asr_pkg::DATA_W-1:0] data_in,    // Resolved data lines
  output logic                            clash       // Both parties drive
);
  logic [asr_pkg::DATA_W-1:0] mem [0:(1<<asr_pkg::ADDR_W)-1];
  logic [asr_pkg::DATA_W-1:0] junk;
  logic                       drv;
  logic                       dvalid;
  logic                       wr;
  logic                       rd;
  int                         tok;
  ////////////////////////////////////////
  // Changing pattern on released lines
  initial
  begin
    junk = 8'h5A;
    drv = 1'b0;
    dvalid = 1'b0;
    tok = 0;
  end
  always @(posedge clk_sys) junk <= ~junk;
  // Byte stored as joint select and strobe end
  assign wr = ~cs_n & ~we_n;
  assign rd = ~cs_n & we_n & ~oe_n;
  always @(negedge wr)
    if (data_oe === 1'b1) mem[addr_lines] = data_out;
  // Float at once, low-Z after 4 ns, data after access time
  always @(cs_n or we_n or oe_n or addr_lines)
  begin
    tok = tok + 1;
    dvalid = 1'b0;
    // Pins read directly; the rd net may not have settled yet
    if (!(cs_n === 1'b0 && we_n === 1'b1 && oe_n === 1'b0)) drv = 1'b0;
    fork
      begin
        automatic int t = tok;
        #4;
        if (t == tok) drv = (rd === 1'b1);
        #(slow ? 10 : 1);
        if (t == tok) dvalid = 1'b1;
      end
    join_none
  end
  // Resolved wire seen by the controller
  assign data_in = data_oe ? data_out
                 : (drv ? (dvalid ? mem[addr_lines] : ~mem[addr_lines]) : junk);
  assign clash = data_oe & drv;
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [18:0] req_addr = 19'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        slow = 1'b0;
  logic        req_ready, rsp_valid, cs_n, we_n, oe_n, data_oe, clash;
  logic [7:0]  rsp_rdata, data_in, data_out;
  logic [18:0] addr_lines;
  logic [7:0]  ref_mem [logic [18:0]];
  logic [18:0] tab [16];
  logic [7:0]  exp_q [$];
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          seed = 32'h5680;
  ////////////////////////////////////////
  always #2.5 clk_sys = ~clk_sys;
  asr_ctrl dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr_lines(addr_lines), .cs_n(cs_n),
    .we_n(we_n), .oe_n(oe_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  asr_sram_model mem_i (.clk_sys(clk_sys), .slow(slow), .addr_lines(addr_lines),
    .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .clash(clash));
  ////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One request, noted in the reference
  task automatic op(input logic w, input logic [18:0] a, input logic [7:0] d);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 50)
    begin
      @(negedge clk_sys);
      k++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    slow = $random(seed);
    if (w) ref_mem[a] = d;
    else exp_q.push_back(ref_mem[a]);
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  // Output watcher and hang guard
  always @(negedge clk_sys)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      finish_test();
    end
    check(clash, 1'b0);
    if (we_n === 1'b0) check({cs_n, oe_n, data_oe}, 3'b011);
    if (rsp_valid === 1'b1)
      check(rsp_rdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  end
  // Boundary addresses, then random mixed traffic back to back
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    check({cs_n, we_n, oe_n, data_oe, req_ready}, 5'b11101);
    tab[0] = 19'h00000;
    tab[1] = 19'h7FFFF;
    for (int i = 2; i < 16; i++) tab[i] = $random(seed);
    for (int i = 0; i < 16; i++) op(1'b1, tab[i], $random(seed));
    for (int i = 0; i < 300; i++)
    begin
      int j;
      j = {$random(seed)} % 16;
      op($random(seed), tab[j], $random(seed));
    end
    for (int i = 0; i < 16; i++) op(1'b0, tab[i], 8'h00);
    repeat (20) @(negedge clk_sys);
    check(exp_q.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
